// File: verilog/seecp_pkg.sv
// Purpose: constants for the serial eeprom command and protection block
// Assumes: status byte layout bit0 ready_n, bit1 write latch, bit2/3 guards, bit7 lock arm
// Notes: write cycle time is a parameter of the top module
package seecp_pkg;
  localparam logic [7:0] OP_SET_WL = 8'h06;
  localparam logic [7:0] OP_CLR_WL = 8'h04;
  localparam logic [7:0] OP_SR_RD = 8'h05;
  localparam logic [7:0] OP_SR_WR = 8'h01;
  localparam logic [7:0] OP_ARR_RD = 8'h03;
  localparam logic [7:0] OP_ARR_WR = 8'h02;
  localparam logic [7:0] OP_ID_RD = 8'h83;
  localparam logic [7:0] OP_ID_WR = 8'h82;
  localparam logic [7:0] OP_MASK = 8'hf7;
  localparam int BIT_RDY = 0;
  localparam int BIT_WEL = 1;
  localparam int BIT_BG_LO = 2;
  localparam int BIT_BG_HI = 3;
  localparam int BIT_ARM = 7;
  localparam int BIT_ID_SEL = 10;
  localparam logic [16:0] QUARTER_BASE = 17'h18000;
  localparam logic [16:0] HALF_BASE = 17'h10000;
  localparam logic [7:0] STATUS_BUSY = 8'hff;
  localparam int WRITE_TIME_US = 5000;
  localparam int CLK_MHZ = 50;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  localparam logic [5:0] OP_BITS = 6'd8;
  localparam logic [5:0] CMD16_BITS = 6'd16;
  localparam logic [5:0] ADDR_END = 6'd32;
  localparam logic [5:0] DATA_END = 6'd40;
endpackage

// File: verilog/seecp_core.sv
// Purpose: instruction decode, write latch, status register and protection of a serial eeprom
// Assumes: sck stops outside frames; cs_n high ends every frame
// Notes: array data path is outside; this block reports decoded requests and guard decisions
`timescale 1ns/100ps
module seecp_core #(
  parameter int WRITE_CYCLES = seecp_pkg::WRITE_CYCLES
) (
  // system
  input wire logic mclk,
  input wire logic rst,
  // serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // guard pin, active low
  input wire logic guard_pin_n,
  // status view
  output logic [7:0] status,
  output logic busy,
  // decoded requests to the array side
  output logic arr_write_go,
  output logic arr_read_sel,
  output logic id_read_sel,
  output logic id_write_go,
  output logic lock_query_sel,
  output logic freeze_go,
  output logic [16:0] req_addr,
  output logic [6:0] id_addr,
  output logic addr_guarded
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_DONE = 3'b100
  } seecp_state_t;

  // link domain: shifting on sck, reset by cs_n high; frame copies taken at cs_n rise, reset by rst
  logic [5:0] bit_cnt;
  logic [7:0] opcode;
  logic [23:0] addr_sh;
  logic [7:0] data_sh;
  logic [7:0] snap_status;
  logic [2:0] out_idx;
  logic frame_tgl;
  logic [7:0] frame_op;
  logic [5:0] frame_bits;
  logic [23:0] frame_addr;
  logic [7:0] frame_data;
  logic [7:0] op_now;

  // system domain
  logic [2:0] tgl_sync;
  logic [2:0] gp_sync;
  logic gp_n;
  logic tgl_seen;
  seecp_state_t state;
  logic [31:0] wr_cnt;
  logic wel;
  logic [1:0] bguard;
  logic arm;
  logic [2:0] pend_sr;
  logic pend_is_sr;
  logic hw_prot;
  logic [7:0] next_status;
  logic [7:0] op_m;
  logic [16:0] a17;

  assign op_now = {opcode[6:0], si};

  // input shift on rising sck, msb first
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt <= 6'd0;
      opcode <= 8'h00;
      addr_sh <= 24'h000000;
      data_sh <= 8'h00;
    end else begin
      if (bit_cnt != 6'h3f) begin
        bit_cnt <= bit_cnt + 6'd1;
      end
      if (bit_cnt < seecp_pkg::OP_BITS) begin
        opcode <= op_now;
      end else if (bit_cnt < seecp_pkg::ADDR_END) begin
        addr_sh <= {addr_sh[22:0], si};
      end
      data_sh <= {data_sh[6:0], si};
    end
  end

  // frame capture at cs rise; the toggle carries it to mclk
  always_ff @(posedge cs_n or posedge rst) begin
    if (rst) begin
      frame_tgl <= 1'b0;
      frame_op <= 8'h00;
      frame_bits <= 6'd0;
      frame_addr <= 24'h000000;
      frame_data <= 8'h00;
    end else begin
      frame_tgl <= ~frame_tgl;
      frame_op <= opcode;
      frame_bits <= bit_cnt;
      frame_addr <= addr_sh;
      frame_data <= data_sh;
    end
  end

  // output on falling sck; status snapshot reloaded every byte
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      so <= 1'b0;
      so_oe <= 1'b0;
      out_idx <= 3'd7;
      snap_status <= 8'h00;
    end else if (bit_cnt >= seecp_pkg::OP_BITS &&
                 (opcode & seecp_pkg::OP_MASK) == seecp_pkg::OP_SR_RD) begin
      so_oe <= 1'b1;
      if (out_idx == 3'd7) begin
        so <= status[7];
        snap_status <= status;
      end else begin
        so <= snap_status[out_idx];
      end
      out_idx <= out_idx - 3'd1;
    end
  end

  // synchronisers: three stages, second and third must agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      tgl_sync <= 3'b000;
      gp_sync <= 3'b111;
      gp_n <= 1'b1;
      tgl_seen <= 1'b0;
    end else begin
      tgl_sync <= {tgl_sync[1:0], frame_tgl};
      gp_sync <= {gp_sync[1:0], guard_pin_n};
      if (gp_sync[2] == gp_sync[1]) begin
        gp_n <= gp_sync[2];
      end
      if (tgl_sync[2] == tgl_sync[1]) begin
        tgl_seen <= tgl_sync[2];
      end
    end
  end

  assign op_m = frame_op & seecp_pkg::OP_MASK;
  assign hw_prot = ~gp_n & arm;

  // frame decode: runs once per ended frame
  logic frame_evt;
  logic op_len_ok;
  logic wr_len_ok;
  assign frame_evt = (tgl_sync[2] == tgl_sync[1]) && (tgl_sync[2] != tgl_seen);
  assign op_len_ok = frame_bits == seecp_pkg::OP_BITS || frame_bits == seecp_pkg::CMD16_BITS;
  assign wr_len_ok = frame_bits > seecp_pkg::ADDR_END && frame_bits[2:0] == 3'd0;
  assign a17 = frame_addr[16:0];

  // protected range check
  always_comb begin
    case (bguard)
      2'b01: addr_guarded = a17 >= seecp_pkg::QUARTER_BASE;
      2'b10: addr_guarded = a17 >= seecp_pkg::HALF_BASE;
      2'b11: addr_guarded = 1'b1;
      default: addr_guarded = 1'b0;
    endcase
  end

  // write cycle state and status register
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= ST_IDLE;
      wr_cnt <= 32'd0;
      wel <= 1'b0;
      bguard <= 2'b00;
      arm <= 1'b0;
      pend_sr <= 3'b000;
      pend_is_sr <= 1'b0;
      arr_write_go <= 1'b0;
      id_write_go <= 1'b0;
      freeze_go <= 1'b0;
      req_addr <= 17'h00000;
      id_addr <= 7'h00;
    end else begin
      arr_write_go <= 1'b0;
      id_write_go <= 1'b0;
      freeze_go <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (frame_evt) begin
            if (op_m == seecp_pkg::OP_SET_WL && op_len_ok) begin
              wel <= 1'b1;
            end else if (op_m == seecp_pkg::OP_CLR_WL && op_len_ok) begin
              wel <= 1'b0;
            end else if (op_m == seecp_pkg::OP_SR_WR && frame_bits == 6'd16 && wel && !hw_prot) begin
              pend_sr <= {frame_data[seecp_pkg::BIT_ARM], frame_data[seecp_pkg::BIT_BG_HI],
                          frame_data[seecp_pkg::BIT_BG_LO]};
              pend_is_sr <= 1'b1;
              wr_cnt <= 32'd0;
              state <= ST_BUSY;
            end else if (op_m == seecp_pkg::OP_ARR_WR && wr_len_ok && wel && !addr_guarded) begin
              req_addr <= a17;
              arr_write_go <= 1'b1;
              pend_is_sr <= 1'b0;
              wr_cnt <= 32'd0;
              state <= ST_BUSY;
            end else if (op_m == seecp_pkg::OP_ID_WR && wr_len_ok && wel) begin
              id_addr <= frame_addr[6:0];
              if (frame_addr[seecp_pkg::BIT_ID_SEL]) begin
                freeze_go <= bguard != 2'b11 && frame_data[1];
              end else begin
                id_write_go <= 1'b1;
              end
              pend_is_sr <= 1'b0;
              wr_cnt <= 32'd0;
              state <= ST_BUSY;
            end
          end
        end
        ST_BUSY: begin
          // frames ending here are dropped; status read needs no action
          wr_cnt <= wr_cnt + 32'd1;
          if (wr_cnt >= WRITE_CYCLES - 1) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (pend_is_sr) begin
            bguard <= pend_sr[1:0];
            if (pend_sr[2] || gp_n) begin
              arm <= pend_sr[2];
            end
          end
          wel <= 1'b0;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // read-side selects follow the latest frame
  always_ff @(posedge mclk) begin
    if (rst) begin
      arr_read_sel <= 1'b0;
      id_read_sel <= 1'b0;
      lock_query_sel <= 1'b0;
    end else if (frame_evt) begin
      arr_read_sel <= state == ST_IDLE && op_m == seecp_pkg::OP_ARR_RD;
      id_read_sel <= state == ST_IDLE && op_m == seecp_pkg::OP_ID_RD && !frame_addr[seecp_pkg::BIT_ID_SEL];
      lock_query_sel <= state == ST_IDLE && op_m == seecp_pkg::OP_ID_RD && frame_addr[seecp_pkg::BIT_ID_SEL];
    end
  end

  assign busy = state != ST_IDLE;

  always_comb begin
    next_status = 8'h00;
    next_status[seecp_pkg::BIT_RDY] = busy;
    next_status[seecp_pkg::BIT_WEL] = wel;
    next_status[seecp_pkg::BIT_BG_LO] = bguard[0];
    next_status[seecp_pkg::BIT_BG_HI] = bguard[1];
    next_status[seecp_pkg::BIT_ARM] = arm;
    if (busy) begin
      next_status = seecp_pkg::STATUS_BUSY;
    end
  end

  // status is sampled by the sck domain only at byte starts with sck idle-high risk; kept registered
  always_ff @(posedge mclk) begin
    if (rst) begin
      status <= 8'h00;
    end else begin
      status <= next_status;
    end
  end

  // status, guard range, request and write cycle checks
  busy_ones_a: assert property (@(posedge mclk) disable iff (rst)
    busy |=> status == 8'hff)
    else $error("status not all ones while busy");
  idle_ready_a: assert property (@(posedge mclk) disable iff (rst)
    !busy |=> !status[0])
    else $error("ready bit set while idle");
  guard_all_a: assert property (@(posedge mclk) disable iff (rst)
    bguard == 2'b11 |-> addr_guarded)
    else $error("full guard not covering address");
  guard_none_a: assert property (@(posedge mclk) disable iff (rst)
    bguard == 2'b00 |-> !addr_guarded)
    else $error("no guard yet address guarded");
  guard_half_a: assert property (@(posedge mclk) disable iff (rst)
    bguard == 2'b10 |-> addr_guarded == a17[16])
    else $error("half guard range wrong");
  guard_quarter_a: assert property (@(posedge mclk) disable iff (rst)
    bguard == 2'b01 |-> addr_guarded == (a17[16] && a17[15]))
    else $error("quarter guard range wrong");
  write_allowed_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(arr_write_go) |-> $past(wel) && !$past(addr_guarded))
    else $error("array write without latch");
  arr_start_a: assert property (@(posedge mclk) disable iff (rst)
    state == ST_IDLE && frame_evt && op_m == seecp_pkg::OP_ARR_WR && wr_len_ok && wel && !addr_guarded
    |=> arr_write_go)
    else $error("legal array write not started");
  arr_refuse_a: assert property (@(posedge mclk) disable iff (rst)
    frame_evt && op_m == seecp_pkg::OP_ARR_WR && addr_guarded |=> !arr_write_go)
    else $error("guarded array write started");
  latch_set_a: assert property (@(posedge mclk) disable iff (rst)
    state == ST_IDLE && frame_evt && op_m == seecp_pkg::OP_SET_WL && op_len_ok |=> wel)
    else $error("write latch not set");
  wel_rise_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(wel) |-> $past(frame_evt) && $past(op_m) == seecp_pkg::OP_SET_WL)
    else $error("write latch set without command");
  latch_clr_a: assert property (@(posedge mclk) disable iff (rst)
    state == ST_IDLE && frame_evt && op_m == seecp_pkg::OP_CLR_WL && op_len_ok |=> !wel)
    else $error("write latch not cleared by command");
  latch_done_a: assert property (@(posedge mclk) disable iff (rst)
    state == ST_DONE |=> !wel)
    else $error("write latch not cleared after cycle");
  sr_start_a: assert property (@(posedge mclk) disable iff (rst)
    state == ST_IDLE && frame_evt && op_m == seecp_pkg::OP_SR_WR && frame_bits == seecp_pkg::CMD16_BITS
    && wel && !hw_prot |=> state == ST_BUSY)
    else $error("legal status write not started");
  sr_refuse_a: assert property (@(posedge mclk) disable iff (rst)
    state == ST_IDLE && frame_evt && op_m == seecp_pkg::OP_SR_WR && (!wel || hw_prot) |=> state == ST_IDLE)
    else $error("refused status write started");
  sr_hold_a: assert property (@(posedge mclk) disable iff (rst)
    state == ST_BUSY |=> $stable(bguard) && $stable(arm))
    else $error("status changed mid cycle");
  sr_commit_a: assert property (@(posedge mclk) disable iff (rst)
    state == ST_DONE && pend_is_sr |=> bguard == pend_sr[1:0])
    else $error("guard bits not stored at cycle end");
  arm_fall_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(arm) |-> $past(gp_n))
    else $error("lock arm fell with pin low");
  arm_keep_a: assert property (@(posedge mclk) disable iff (rst)
    state == ST_DONE && !gp_n && arm |=> arm)
    else $error("lock arm cleared with pin low");
  busy_ignore_a: assert property (@(posedge mclk) disable iff (rst)
    state == ST_BUSY |=> !arr_write_go && !id_write_go)
    else $error("request taken while busy");
  busy_reads_a: assert property (@(posedge mclk) disable iff (rst)
    frame_evt && state != ST_IDLE |=> !arr_read_sel && !id_read_sel && !lock_query_sel)
    else $error("read selected while busy");
  cnt_bound_a: assert property (@(posedge mclk) disable iff (rst)
    state == ST_BUSY |-> wr_cnt < WRITE_CYCLES)
    else $error("write cycle counter overran");
  id_start_a: assert property (@(posedge mclk) disable iff (rst)
    state == ST_IDLE && frame_evt && op_m == seecp_pkg::OP_ID_WR && wr_len_ok && wel
    && !frame_addr[seecp_pkg::BIT_ID_SEL] |=> id_write_go)
    else $error("legal id page write not started");
  freeze_guard_a: assert property (@(posedge mclk) disable iff (rst)
    freeze_go |-> bguard != 2'b11)
    else $error("page freeze with full guard");
  id_sel_excl_a: assert property (@(posedge mclk) disable iff (rst)
    !(id_read_sel && lock_query_sel))
    else $error("page read and lock query both selected");
  // link side: so only driven in the status read output phase
  so_src_a: assert property (@(posedge sck) disable iff (cs_n)
    so_oe |-> (opcode & seecp_pkg::OP_MASK) == seecp_pkg::OP_SR_RD)
    else $error("so driven outside status read");
endmodule

// File: bench/seecp_master.sv
// Purpose: serial bus master model for the eeprom command block
// Assumes: link clock period 32 ns, low and still outside frames
// Notes: so sampled on rising sck; si scrambled once released
`timescale 1ns/100ps
module seecp_master (
  // link
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // one frame of n bits, msb first; q returns what so carried
  task automatic xfer(input logic [47:0] d, input int n, output logic [47:0] q);
    q = '0;
    #7 cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si = d[i];
      #16 sck = 1'b1;
      q = {q[46:0], so};
      #16 sck = 1'b0;
    end
    #8 cs_n = 1'b1;
    si = ~si;
  endtask
endmodule

// File: bench/tb_serial_eeprom_cmd_protect.sv
// Purpose: self-checking bench for the eeprom command and protection block
// Assumes: write cycle shortened to 200 mclk
// Notes: decode lag is a few mclk, so each frame is followed by 8 mclk
`timescale 1ns/100ps
module tb_serial_eeprom_cmd_protect;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic guard_pin_n = 1'b1;
  logic sck, cs_n, si, so, so_oe, busy, addr_guarded;
  logic arr_write_go, arr_read_sel, id_read_sel, id_write_go, lock_query_sel, freeze_go;
  logic [7:0] status;
  logic [16:0] req_addr;
  logic [6:0] id_addr;
  logic [47:0] q;
  int miscompares = 0;
  int samples_checked = 0;
  int wr_pulses = 0;
  int id_pulses = 0;
  int frz_pulses = 0;
  int oe_seen = 0;
  always #10 mclk = ~mclk;
  always @(posedge mclk) if (arr_write_go === 1'b1) wr_pulses++;
  always @(posedge mclk) if (id_write_go === 1'b1) id_pulses++;
  always @(posedge mclk) if (freeze_go === 1'b1) frz_pulses++;
  always @(posedge sck) if (so_oe === 1'b1) oe_seen++;
  seecp_core #(.WRITE_CYCLES(200)) dut_u (.mclk(mclk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
    .so(so), .so_oe(so_oe), .guard_pin_n(guard_pin_n), .status(status), .busy(busy),
    .arr_write_go(arr_write_go), .arr_read_sel(arr_read_sel), .id_read_sel(id_read_sel),
    .id_write_go(id_write_go), .lock_query_sel(lock_query_sel), .freeze_go(freeze_go),
    .req_addr(req_addr), .id_addr(id_addr), .addr_guarded(addr_guarded));
  seecp_master mst_u (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic frame(input logic [47:0] d, input int n);
    mst_u.xfer(d, n, q);
    repeat (8) @(posedge mclk);
  endtask
  // bounded: a stuck write cycle ends the run
  task automatic wait_idle();
    int k;
    for (k = 0; k < 400 && busy !== 1'b0; k++) @(posedge mclk);
    if (k == 400) begin
      miscompares++;
      $display("[FAIL] busy expected 0 seen 1");
      test_done();
    end
    // status register trails busy by one stage
    repeat (2) @(posedge mclk);
  endtask
  task automatic rd_status(input logic [7:0] exp);
    int oe0;
    oe0 = oe_seen;
    mst_u.xfer(48'h050000, 24, q);
    chk("so_oe edges", 17'd16, 17'(oe_seen - oe0));
    chk("so status first", 17'(exp), 17'(q[15:8]));
    chk("so status repeat", 17'(exp), 17'(q[7:0]));
    repeat (8) @(posedge mclk);
  endtask
  task automatic test_reset();
    chk("status after reset", 17'h0, 17'(status));
    rd_status(8'h00);
  endtask
  task automatic test_latch();
    frame(48'h06, 8);
    chk("latch set", 17'h2, 17'(status));
    frame(48'h04a5, 16);
    chk("latch clear 16", 17'h0, 17'(status));
    frame(48'h0e5a, 16);
    chk("latch set bit3", 17'h2, 17'(status));
    rd_status(8'h02);
    frame(48'h0c, 8);
    chk("latch clear", 17'h0, 17'(status));
  endtask
  task automatic test_sr_write();
    frame(48'h06, 8);
    frame(48'h09fd, 16);
    chk("busy in write", 17'h1, 17'(busy));
    chk("status in write", 17'hff, 17'(status));
    rd_status(8'hff);
    frame(48'h06, 8); // dropped while busy
    wait_idle();
    chk("status stored", 17'h8c, 17'(status));
    rd_status(8'h8c); // reread once ready has dropped
  endtask
  task automatic test_guard();
    guard_pin_n <= 1'b0;
    repeat (6) @(posedge mclk);
    frame(48'h06, 8);
    chk("latch under guard", 17'h8e, 17'(status));
    frame(48'h0100, 16);
    chk("hw guard busy", 17'h0, 17'(busy));
    chk("hw guard status", 17'h8e, 17'(status));
    frame(48'h0200001055, 40);
    chk("all guarded", 17'h1, 17'(addr_guarded));
    chk("guarded write", 17'h0, 17'(wr_pulses));
    guard_pin_n <= 1'b1;
    repeat (6) @(posedge mclk);
    frame(48'h06, 8);
    frame(48'h0104, 16);
    repeat (220) @(posedge mclk); // fixed wait in place of polling
    chk("arm cleared", 17'h04, 17'(status));
    frame(48'h06, 8);
    frame(48'h02fe800055, 40);
    chk("write started", 17'h1, 17'(wr_pulses));
    chk("array addr", 17'h08000, req_addr);
    chk("unguarded", 17'h0, 17'(addr_guarded));
    wait_idle();
    chk("latch after write", 17'h04, 17'(status));
    frame(48'h06, 8);
    frame(48'h0201800055, 40);
    chk("quarter guarded", 17'h1, 17'(addr_guarded));
    chk("quarter write", 17'h1, 17'(wr_pulses));
  endtask
  task automatic test_id();
    frame(48'h06, 8);
    frame(48'h8200004511, 40);
    chk("id write pulse", 17'h1, 17'(id_pulses));
    chk("id addr", 17'h45, 17'(id_addr));
    wait_idle();
    frame(48'h06, 8);
    frame(48'h8a00040002, 40);
    chk("freeze pulse", 17'h1, 17'(frz_pulses));
    chk("id write once", 17'h1, 17'(id_pulses));
    wait_idle();
    frame(48'h03000000, 32);
    chk("array read sel", 17'h1, 17'(arr_read_sel));
    frame(48'h83000000, 32);
    chk("id read sel", 17'h1, 17'(id_read_sel));
    frame(48'h8b000400, 32);
    chk("lock query sel", 17'h1, 17'(lock_query_sel));
    chk("id read off", 17'h0, 17'(id_read_sel));
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (6) @(posedge mclk);
    test_reset();
    test_latch();
    test_sr_write();
    test_guard();
    test_id();
    test_done();
  end
endmodule
